/* hdl/reload_capture_timer16.sv */
// 16-bit reload/capture timer with baud clock outputs and an Avalon-MM register slave
`timescale 1ns/1ps
`include "reload_capture_timer16_consts.svh"

module reload_capture_timer16 (
  // clock and reset
  input  wire logic                                i_mclk,
  input  wire logic                                i_reset_n,
  // register bus
  input  wire reload_capture_timer16_pkg::avmm_req_t i_avs,
  output logic [31:0]                              o_avs_readdata,
  output logic                                     o_avs_waitrequest,
  // external pins
  input  wire logic                                i_count_input_pin,
  input  wire logic                                i_trigger_direction_pin,
  // serial port clocking
  input  wire logic                                i_other_timer_ovf,
  output logic                                     o_rx_baud_tick,
  output logic                                     o_tx_baud_tick,
  // interrupt request
  output logic                                     o_irq
);
  import reload_capture_timer16_pkg::*;

  timer_state_t st_ff;
  timer_state_t nxt_st;

  logic       baud_mode;
  logic       upd;
  logic       sw_wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic       trig_ok;
  logic       ovf_ev;
  logic       tf_set;
  logic       exf_set;
  logic       exf_tgl;

  assign idx       = i_avs.address[9:2];
  assign wbyte     = i_avs.writedata[7:0];
  assign baud_mode = st_ff.ctrl.rx_baud_source_sel | st_ff.ctrl.tx_baud_source_sel; // [R21]
  assign upd       = (st_ff.phase == `PH_UPDATE);
  assign sw_wr     = (st_ff.bus == BUS_DONE) & i_avs.write & i_avs.byteenable[0];
  assign trig_ok   = st_ff.pend_trig & st_ff.ctrl.ext_trigger_enable & ~baud_mode; // [R5]

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_avs_readdata    = {24'h000000, st_ff.rdata};
  assign o_avs_waitrequest = (i_avs.read | i_avs.write) & (st_ff.bus == BUS_IDLE);
  assign o_rx_baud_tick    = st_ff.rx_tick;
  assign o_tx_baud_tick    = st_ff.tx_tick;
  // event flag never interrupts in up/down mode
  assign o_irq = st_ff.irq_enable & (st_ff.ctrl.overflow_flag |
                 (st_ff.ctrl.external_event_flag & ~st_ff.down_count_enable)); // [R14]

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st  = st_ff;
    ovf_ev  = 1'b0;
    tf_set  = 1'b0;
    exf_set = 1'b0;
    exf_tgl = 1'b0;

    // machine cycle phase counter
    if (st_ff.phase == `MC_LAST) begin
      nxt_st.phase = 4'h0;
    end else begin
      nxt_st.phase = st_ff.phase + 4'h1;
    end

    // pins sampled once per machine cycle; the step lands in the next cycle
    if (st_ff.phase == `PH_SAMPLE) begin // [R18]
      nxt_st.cnt_smp   = i_count_input_pin; // [R23]
      nxt_st.trg_smp   = i_trigger_direction_pin;
      nxt_st.pend_dir  = i_trigger_direction_pin;
      nxt_st.pend_trig = st_ff.trg_smp & ~i_trigger_direction_pin;
      if (st_ff.ctrl.count_source_sel) begin // [R7]
        nxt_st.pend_inc = st_ff.ctrl.run_control & st_ff.cnt_smp & ~i_count_input_pin; // [R23]
      end else begin
        nxt_st.pend_inc = st_ff.ctrl.run_control; // [R22] [R6]
      end
    end

    // count update at the update phase
    if (upd) begin // [R18]
      if (baud_mode) begin // [R9]
        if (st_ff.pend_inc) begin
          if (st_ff.cnt == `CNT_MAX) begin
            nxt_st.cnt = st_ff.rc;
            ovf_ev     = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
          end
        end
      end else if (st_ff.ctrl.capture_reload_sel) begin // [R8]
        if (st_ff.pend_inc) begin
          nxt_st.cnt = st_ff.cnt + 16'h0001; // [R25] [R19]
          if (st_ff.cnt == `CNT_MAX) begin
            ovf_ev = 1'b1;
            tf_set = 1'b1;
          end
        end
        if (trig_ok) begin
          nxt_st.rc = st_ff.cnt; // [R20]
          exf_set   = 1'b1; // [R2]
        end
      end else if (st_ff.down_count_enable) begin
        if (st_ff.pend_inc) begin
          if (st_ff.pend_dir) begin
            if (st_ff.cnt == `CNT_MAX) begin // [R15]
              nxt_st.cnt = st_ff.rc;
              ovf_ev     = 1'b1;
              tf_set     = 1'b1;
              exf_tgl    = 1'b1; // [R17]
            end else begin
              nxt_st.cnt = st_ff.cnt + 16'h0001;
            end
          end else if (st_ff.cnt == st_ff.rc) begin // [R16]
            nxt_st.cnt = `CNT_MAX;
            ovf_ev     = 1'b1;
            tf_set     = 1'b1;
            exf_tgl    = 1'b1; // [R17]
          end else begin
            nxt_st.cnt = st_ff.cnt - 16'h0001;
          end
        end
      end else begin
        if (st_ff.pend_inc) begin
          if (st_ff.cnt == `CNT_MAX) begin // [R12]
            nxt_st.cnt = st_ff.rc;
            ovf_ev     = 1'b1;
            tf_set     = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
          end
        end
        if (trig_ok) begin // [R13]
          nxt_st.cnt = st_ff.rc;
          exf_set    = 1'b1; // [R2]
        end
      end
    end

    // serial clock selection
    nxt_st.rx_tick = st_ff.ctrl.rx_baud_source_sel ? ovf_ev : i_other_timer_ovf; // [R3]
    nxt_st.tx_tick = st_ff.ctrl.tx_baud_source_sel ? ovf_ev : i_other_timer_ovf; // [R4]

    // bus slave: one wait cycle, then the access completes
    case (st_ff.bus)
      BUS_IDLE: begin
        if (i_avs.read | i_avs.write) begin
          nxt_st.bus = BUS_DONE;
          case (idx)
            `IDX_CTRL:     nxt_st.rdata = st_ff.ctrl;
            `IDX_MODE:     nxt_st.rdata = {7'h00, st_ff.down_count_enable}; // [R11]
            `IDX_RC_LOW:   nxt_st.rdata = st_ff.rc[7:0];
            `IDX_RC_HIGH:  nxt_st.rdata = st_ff.rc[15:8];
            `IDX_CNT_LOW:  nxt_st.rdata = st_ff.cnt[7:0];
            `IDX_CNT_HIGH: nxt_st.rdata = st_ff.cnt[15:8];
            `IDX_IRQ_EN:   nxt_st.rdata = {7'h00, st_ff.irq_enable};
            default:       nxt_st.rdata = 8'h00;
          endcase
        end
      end
      BUS_DONE: begin
        nxt_st.bus = BUS_IDLE;
      end
      default: begin
        nxt_st.bus = BUS_IDLE;
      end
    endcase

    // software writes; data registers take the software value
    if (sw_wr) begin
      case (idx)
        `IDX_CTRL:     nxt_st.ctrl = wbyte;
        `IDX_MODE:     nxt_st.down_count_enable = wbyte[`MODE_DOWN_EN_BIT]; // [R11]
        `IDX_RC_LOW:   nxt_st.rc[7:0] = wbyte;
        `IDX_RC_HIGH:  nxt_st.rc[15:8] = wbyte;
        `IDX_CNT_LOW:  nxt_st.cnt[7:0] = wbyte;
        `IDX_CNT_HIGH: nxt_st.cnt[15:8] = wbyte;
        `IDX_IRQ_EN:   nxt_st.irq_enable = wbyte[`IRQ_EN_BIT];
        default:       nxt_st.rdata = st_ff.rdata;
      endcase
    end

    // hardware flag events win over a software clear
    if (tf_set & ~baud_mode) begin // [R1]
      nxt_st.ctrl.overflow_flag = 1'b1;
    end
    if (exf_set) begin // [R2]
      nxt_st.ctrl.external_event_flag = 1'b1;
    end else if (exf_tgl) begin // [R17]
      nxt_st.ctrl.external_event_flag = ~st_ff.ctrl.external_event_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_ff                   <= '0;
      st_ff.bus               <= BUS_IDLE;
      st_ff.ctrl              <= `CTRL_RESET; // [R10]
      st_ff.down_count_enable <= 1'b0; // [R11]
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  logic quiet;
  assign quiet = ~sw_wr;

  ovf_no_baud_a: assert property (baud_mode && quiet |=> // [R1]
    !$rose(st_ff.ctrl.overflow_flag))
    else $error("overflow flag set in baud mode");

  flag_hold_a: assert property (st_ff.ctrl.overflow_flag && quiet // [R1]
    |=> st_ff.ctrl.overflow_flag)
    else $error("overflow flag lost without software clear");

  trig_ignored_a: assert property (upd && st_ff.pend_trig && // [R5]
    !st_ff.ctrl.ext_trigger_enable && !st_ff.pend_inc && quiet |=> $stable(st_ff.cnt)
    && $stable(st_ff.rc))
    else $error("trigger acted while disabled");

  stop_hold_a: assert property (st_ff.phase == `PH_SAMPLE && // [R6]
    !st_ff.ctrl.run_control |=> !st_ff.pend_inc)
    else $error("count step taken while stopped");

  update_phase_a: assert property (!upd && quiet |=> $stable(st_ff.cnt)) // [R18]
    else $error("count changed outside update phase");

  sample_phase_a: assert property (st_ff.phase != `PH_SAMPLE // [R18]
    |=> $stable(st_ff.pend_inc) && $stable(st_ff.trg_smp))
    else $error("pins sampled outside sample phase");

  machine_cycle_a: assert property (upd |-> ##12 upd) // [R22]
    else $error("machine cycle is not 12 clocks");

  reload_ovf_a: assert property (upd && quiet && !baud_mode && // [R12]
    !st_ff.ctrl.capture_reload_sel && !st_ff.down_count_enable && st_ff.pend_inc &&
    !trig_ok && st_ff.cnt == `CNT_MAX |=> st_ff.cnt == $past(st_ff.rc) &&
    st_ff.ctrl.overflow_flag)
    else $error("reload on overflow missing");

  capture_wrap_a: assert property (upd && quiet && !baud_mode && // [R25]
    st_ff.ctrl.capture_reload_sel && st_ff.pend_inc && st_ff.cnt == `CNT_MAX
    |=> st_ff.cnt == 16'h0000 && st_ff.ctrl.overflow_flag)
    else $error("capture mode did not wrap");

  down_uflow_a: assert property (upd && quiet && !baud_mode && // [R16]
    !st_ff.ctrl.capture_reload_sel && st_ff.down_count_enable && st_ff.pend_inc &&
    !st_ff.pend_dir && st_ff.cnt == st_ff.rc |=> st_ff.cnt == `CNT_MAX &&
    st_ff.ctrl.external_event_flag != $past(st_ff.ctrl.external_event_flag))
    else $error("underflow handling wrong");

  capture_copy_a: assert property (upd && quiet && trig_ok && // [R20]
    st_ff.ctrl.capture_reload_sel |=> st_ff.rc == $past(st_ff.cnt) &&
    st_ff.ctrl.external_event_flag)
    else $error("capture did not copy count");

  updown_irq_a: assert property (st_ff.down_count_enable && // [R17]
    !st_ff.ctrl.overflow_flag |-> !o_irq)
    else $error("event flag interrupted in up/down mode");

  rx_baud_a: assert property (st_ff.ctrl.rx_baud_source_sel && ovf_ev // [R3]
    |=> o_rx_baud_tick)
    else $error("receive baud tick missing");

  tx_baud_a: assert property (!st_ff.ctrl.tx_baud_source_sel && // [R4]
    i_other_timer_ovf |=> o_tx_baud_tick)
    else $error("transmit tick not from other timer");

  exf_hold_a: assert property (st_ff.ctrl.external_event_flag && quiet && // [R2]
    !st_ff.down_count_enable |=> st_ff.ctrl.external_event_flag)
    else $error("event flag lost without software clear");

  rx_other_a: assert property (!st_ff.ctrl.rx_baud_source_sel && // [R3]
    i_other_timer_ovf |=> o_rx_baud_tick)
    else $error("receive tick not from other timer");

  tx_own_a: assert property (st_ff.ctrl.tx_baud_source_sel && ovf_ev // [R4]
    |=> o_tx_baud_tick)
    else $error("transmit baud tick missing");

  rx_quiet_a: assert property (st_ff.ctrl.rx_baud_source_sel && !ovf_ev // [R3]
    |=> !o_rx_baud_tick)
    else $error("receive tick without overflow");

  baud_trig_a: assert property (upd && quiet && baud_mode && // [R5]
    !st_ff.pend_inc |=> $stable(st_ff.cnt) && $stable(st_ff.rc))
    else $error("trigger acted in baud mode");

  pin_edge_a: assert property (st_ff.phase == `PH_SAMPLE && // [R7]
    st_ff.ctrl.count_source_sel && !(st_ff.cnt_smp && !i_count_input_pin)
    |=> !st_ff.pend_inc)
    else $error("count pin step without falling edge");

  timer_step_a: assert property (st_ff.phase == `PH_SAMPLE && // [R22]
    !st_ff.ctrl.count_source_sel && st_ff.ctrl.run_control |=> st_ff.pend_inc)
    else $error("machine cycle step missing");

  baud_reload_a: assert property (upd && quiet && baud_mode && // [R9]
    st_ff.pend_inc && st_ff.cnt == `CNT_MAX |=> st_ff.cnt == $past(st_ff.rc) &&
    !$rose(st_ff.ctrl.overflow_flag))
    else $error("baud mode did not auto-reload");

  mode_read_a: assert property (st_ff.bus == BUS_IDLE && i_avs.read && // [R11]
    idx == `IDX_MODE |=> st_ff.rdata[7:1] == 7'h00)
    else $error("mode register reserved bits not zero");

  up_ovf_a: assert property (upd && quiet && !baud_mode && // [R15]
    !st_ff.ctrl.capture_reload_sel && st_ff.down_count_enable && st_ff.pend_inc &&
    st_ff.pend_dir && st_ff.cnt == `CNT_MAX |=> st_ff.cnt == $past(st_ff.rc) &&
    st_ff.ctrl.overflow_flag)
    else $error("up count overflow handling wrong");

  down_step_a: assert property (upd && quiet && !baud_mode && // [R16]
    !st_ff.ctrl.capture_reload_sel && st_ff.down_count_enable && st_ff.pend_inc &&
    !st_ff.pend_dir && st_ff.cnt != st_ff.rc
    |=> st_ff.cnt == $past(st_ff.cnt) - 16'h0001)
    else $error("down count step wrong");

  reload_trig_a: assert property (upd && quiet && trig_ok && // [R13]
    !st_ff.ctrl.capture_reload_sel && !st_ff.down_count_enable
    |=> st_ff.cnt == $past(st_ff.rc) && st_ff.ctrl.external_event_flag)
    else $error("trigger reload missing");

  irq_on_a: assert property (st_ff.irq_enable && st_ff.ctrl.overflow_flag // [R14]
    |-> o_irq)
    else $error("overflow flag did not interrupt");

  irq_off_a: assert property (!st_ff.irq_enable |-> !o_irq) // [R14]
    else $error("interrupt while disabled");

  rc_hold_a: assert property (quiet && !st_ff.ctrl.capture_reload_sel // [R12]
    |=> $stable(st_ff.rc))
    else $error("reload pair changed without software");

endmodule

/* hdl/reload_capture_timer16_consts.svh */
// register offsets, field positions, reset values and phase timing of the timer
// Operation
// [R1] overflow flag set on each overflow, never while any baud select is 1
// [R2] external event flag set by enabled trigger capture or reload; software clears
// [R3] receive baud select 1 routes our overflows to serial receive clock, else other timer
// [R4] transmit baud select 1 routes our overflows to serial transmit clock, else other timer
// [R5] trigger edge acts only when enabled and not in baud mode
// [R6] counting happens only while run control is 1
// [R7] count source 0 counts machine cycles, 1 counts count-pin falling edges
// [R8] capture select 1 captures on trigger; 0 reloads on overflow and trigger
// [R9] any baud select forces auto-reload on overflow, ignoring capture select
// [R10] reset clears the whole control register
// [R11] mode register holds only down count enable in bit 0, reset 0
// [R12] up-only reload mode counts to FFFF, sets overflow flag, loads reload pair
// [R13] up-only reload mode with trigger reloads on trigger edge and sets event flag
// [R14] interrupt from either flag when enabled; event flag excluded in up/down mode
// [R15] down-enabled with trigger pin high counts up; FFFF overflow reloads pair
// [R16] down-enabled with trigger pin low counts down; at reload value loads FFFF
// [R17] up/down mode toggles event flag on overflow and underflow, no interrupt
// [R18] trigger pin sampled at sample phase, step applied at next update phase
// [R19] capture mode without trigger is plain 16-bit timer setting overflow flag
// [R20] capture with trigger copies count into reload pair and sets event flag
// [R21] baud mode whenever either baud source select is 1
// [R22] timer function advances once per 12-clock machine cycle
// [R23] count pin sampled each machine cycle; high then low counts once
// [R24] external source holds each count level at least one machine cycle
// [R25] capture mode count wraps from all ones to zero without reload
`ifndef RELOAD_CAPTURE_TIMER16_CONSTS_SVH
`define RELOAD_CAPTURE_TIMER16_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_CTRL      8'hC8
`define IDX_MODE      8'hC9
`define IDX_RC_LOW    8'hCA
`define IDX_RC_HIGH   8'hCB
`define IDX_CNT_LOW   8'hCC
`define IDX_CNT_HIGH  8'hCD
`define IDX_IRQ_EN    8'hCE

`define CTRL_RESET    8'h00
`define MODE_DOWN_EN_BIT 0
`define IRQ_EN_BIT    0
`define CNT_MAX       16'hFFFF

// machine cycle of 12 clocks; pin sample phase and count update phase
`define MC_CLOCKS     12
`define MC_LAST       4'hB
`define PH_SAMPLE     4'h9
`define PH_UPDATE     4'h4

`endif

/* hdl/reload_capture_timer16_pkg.sv */
// types shared by the reload/capture timer
package reload_capture_timer16_pkg;

  typedef enum logic {BUS_IDLE, BUS_DONE} bus_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [9:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avmm_req_t;

  typedef struct packed {
    logic overflow_flag;
    logic external_event_flag;
    logic rx_baud_source_sel;
    logic tx_baud_source_sel;
    logic ext_trigger_enable;
    logic run_control;
    logic count_source_sel;
    logic capture_reload_sel;
  } timer_control_t;

  typedef struct packed {
    bus_state_t     bus;
    logic [7:0]     rdata;
    timer_control_t ctrl;
    logic           down_count_enable;
    logic           irq_enable;
    logic [15:0]    cnt;
    logic [15:0]    rc;
    logic [3:0]     phase;
    logic           cnt_smp;
    logic           trg_smp;
    logic           pend_inc;
    logic           pend_dir;
    logic           pend_trig;
    logic           rx_tick;
    logic           tx_tick;
  } timer_state_t;

endpackage

/* tb/pin_source.sv */
// model of the external count and trigger/direction pin drivers
`timescale 1ns/1ps

module pin_source (
  // clock
  input  wire logic i_mclk,
  // pins toward the timer
  output logic      o_count_input_pin,
  output logic      o_trigger_direction_pin
);
  // two machine cycles per level so every level is sampled at least once
  localparam int HOLD = 24;

  initial begin
    o_count_input_pin       = 1'b0;
    o_trigger_direction_pin = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic trig_fall();
    @(posedge i_mclk);
    o_trigger_direction_pin <= 1'b0;
    repeat (HOLD) @(posedge i_mclk);
    o_trigger_direction_pin <= 1'b1;
    repeat (HOLD) @(posedge i_mclk);
  endtask

  task automatic set_dir(input logic up);
    @(posedge i_mclk);
    o_trigger_direction_pin <= up;
    repeat (HOLD) @(posedge i_mclk);
  endtask

  task automatic count_pulses(input int n);
    repeat (n) begin
      o_count_input_pin <= 1'b1;
      repeat (HOLD) @(posedge i_mclk);
      o_count_input_pin <= 1'b0;
      repeat (HOLD) @(posedge i_mclk);
    end
  endtask
endmodule

/* tb/reload_capture_timer16_tb.sv */
// self-checking bench for the reload/capture timer
`timescale 1ns/1ps

module reload_capture_timer16_tb;
  import reload_capture_timer16_pkg::*;

  logic        i_mclk;
  logic        i_reset_n;
  avmm_req_t   avs;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic        cnt_pin;
  logic        trg_pin;
  logic        other_ovf;
  logic        o_rx_baud_tick;
  logic        o_tx_baud_tick;
  logic        o_irq;
  logic [7:0]  rdv;
  int          bad_count;
  int          samples_checked;
  int          rx_n;
  int          tx_n;
  int          cyc;
  int          wn;

  reload_capture_timer16 u_dut (
    .i_mclk                  (i_mclk),
    .i_reset_n               (i_reset_n),
    .i_avs                   (avs),
    .o_avs_readdata          (o_avs_readdata),
    .o_avs_waitrequest       (o_avs_waitrequest),
    .i_count_input_pin       (cnt_pin),
    .i_trigger_direction_pin (trg_pin),
    .i_other_timer_ovf       (other_ovf),
    .o_rx_baud_tick          (o_rx_baud_tick),
    .o_tx_baud_tick          (o_tx_baud_tick),
    .o_irq                   (o_irq)
  );

  pin_source u_src (
    .i_mclk                  (i_mclk),
    .o_count_input_pin       (cnt_pin),
    .o_trigger_direction_pin (trg_pin)
  );

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    if (o_rx_baud_tick === 1'b1) rx_n++;
    if (o_tx_baud_tick === 1'b1) tx_n++;
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic bit_chk(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask

  // one bus cycle; the request stands until waitrequest is seen low
  task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [3:0] be, output logic [7:0] rd);
    int n;
    avs.read       <= !wr_en;
    avs.write      <= wr_en;
    avs.address    <= {idx, 2'b00};
    avs.writedata  <= {24'h000000, wd};
    avs.byteenable <= be;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) bad_count++;
    rd = o_avs_readdata[7:0];
    avs.read  <= 1'b0;
    avs.write <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    bus(1'b1, idx, wd, 4'hF, d);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, 4'hF, d);
    check8(d, exp);
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    while (o_irq !== 1'b1 && n < 400) begin
      @(posedge i_mclk);
      n++;
    end
    if (n >= 400) bad_count++;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    avs = '0;
    other_ovf = 1'b0;
    i_reset_n = 1'b0;
    {bad_count, samples_checked, rx_n, tx_n, cyc} = '0;
    repeat (20) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    @(posedge i_mclk);
    rd_chk(8'hC8, 8'h00);
    rd_chk(8'hC9, 8'h00);
    bit_chk(o_irq, 1'b0);
    wr(8'hCF, 8'h5A);
    rd_chk(8'hCF, 8'h00);
    bus(1'b1, 8'hCA, 8'hEE, 4'h0, rdv);
    rd_chk(8'hCA, 8'h00);
    wr(8'hC9, 8'hFF);
    rd_chk(8'hC9, 8'h01);
    wr(8'hC9, 8'h00);
    // up count with reload on overflow
    wr(8'hCE, 8'h01);
    wr(8'hCA, 8'h34);
    wr(8'hCB, 8'h12);
    wr(8'hCC, 8'hF4);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    wait_irq(wn);
    bit_chk(wn >= 132 && wn <= 156, 1'b1);
    wr(8'hC8, 8'h80);
    rd_chk(8'hC8, 8'h80);
    rd_chk(8'hCD, 8'h12);
    repeat (40) @(posedge i_mclk);
    rd_chk(8'hCC, 8'h34);
    // capture mode wraps freely
    wr(8'hC8, 8'h00);
    bit_chk(o_irq, 1'b0);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h05);
    wait_irq(wn);
    wr(8'hC8, 8'h81);
    rd_chk(8'hCC, 8'h00);
    rd_chk(8'hCD, 8'h00);
    // capture on trigger
    wr(8'hC8, 8'h09);
    wr(8'hCC, 8'h21);
    wr(8'hCD, 8'h43);
    u_src.trig_fall();
    rd_chk(8'hCA, 8'h21);
    rd_chk(8'hCB, 8'h43);
    rd_chk(8'hC8, 8'h49);
    bit_chk(o_irq, 1'b1);
    // reload on trigger
    wr(8'hC8, 8'h08);
    wr(8'hCA, 8'h78);
    wr(8'hCB, 8'h56);
    wr(8'hCC, 8'h00);
    u_src.trig_fall();
    rd_chk(8'hCC, 8'h78);
    rd_chk(8'hCD, 8'h56);
    rd_chk(8'hC8, 8'h48);
    // trigger disabled
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'h11);
    u_src.trig_fall();
    rd_chk(8'hCC, 8'h11);
    rd_chk(8'hC8, 8'h00);
    // baud generator: capture select and trigger ignored
    wr(8'hCA, 8'hF0);
    wr(8'hCB, 8'hFF);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    rx_n = 0;
    tx_n = 0;
    wr(8'hC8, 8'h3D);
    u_src.trig_fall();
    repeat (300) @(posedge i_mclk);
    rd_chk(8'hC8, 8'h3D);
    bit_chk(o_irq, 1'b0);
    bit_chk(rx_n > 0, 1'b1);
    bit_chk(tx_n > 0, 1'b1);
    wr(8'hC8, 8'h30);
    rd_chk(8'hCD, 8'hFF);
    // receive clock from the other timer
    wr(8'hC8, 8'h10);
    rx_n = 0;
    tx_n = 0;
    other_ovf <= 1'b1;
    @(posedge i_mclk);
    other_ovf <= 1'b0;
    repeat (5) @(posedge i_mclk);
    bit_chk(rx_n == 1, 1'b1);
    bit_chk(tx_n == 0, 1'b1);
    // transmit clock from the other timer
    wr(8'hC8, 8'h20);
    rx_n = 0;
    tx_n = 0;
    other_ovf <= 1'b1;
    @(posedge i_mclk);
    other_ovf <= 1'b0;
    repeat (5) @(posedge i_mclk);
    bit_chk(tx_n == 1, 1'b1);
    bit_chk(rx_n == 0, 1'b1);
    // counter function
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'h00);
    wr(8'hCD, 8'h00);
    wr(8'hC8, 8'h06);
    u_src.count_pulses(3);
    wr(8'hC8, 8'h02);
    rd_chk(8'hCC, 8'h03);
    // up/down: count down to the reload value
    wr(8'hC9, 8'h01);
    u_src.set_dir(1'b0);
    wr(8'hCA, 8'h00);
    wr(8'hCB, 8'h01);
    wr(8'hCC, 8'h02);
    wr(8'hCD, 8'h01);
    wr(8'hC8, 8'h04);
    wait_irq(wn);
    rd_chk(8'hC8, 8'hC4);
    wr(8'hC8, 8'h40);
    bit_chk(o_irq, 1'b0);
    rd_chk(8'hCC, 8'hFF);
    rd_chk(8'hCD, 8'hFF);
    // up/down: count up through all ones
    u_src.set_dir(1'b1);
    wr(8'hCA, 8'hAA);
    wr(8'hCB, 8'h00);
    wr(8'hCC, 8'hFE);
    wr(8'hC8, 8'h44);
    wait_irq(wn);
    rd_chk(8'hC8, 8'h84);
    wr(8'hC8, 8'h00);
    rd_chk(8'hCC, 8'hAA);
    final_report();
  end
endmodule
